// File: hw/irs_defines.vh
// Purpose: constants for the image readout sequencer
// Assumes: included by bare name from the sequencer source
// Notes  : offsets are register indices on the 8-bit address port
`ifndef IRS_DEFINES_VH
`define IRS_DEFINES_VH

// ************************************************************
// Register offsets
// ************************************************************
`define IRS_A_CTRL 8'h03
`define IRS_A_CFG  8'h04
`define IRS_A_GLB  8'h05
`define IRS_A_STAT 8'h06
`define IRS_A_SEQA 8'h17
`define IRS_A_SEQB 8'h18
`define IRS_A_ROWS 8'h20
`define IRS_A_COLS 8'h21
`define IRS_A_OVS  8'h22
`define IRS_A_DLN  8'h23
`define IRS_A_DPX  8'h24
`define IRS_A_HBL  8'h25
`define IRS_A_EXP  8'h26

// ************************************************************
// Field positions
// ************************************************************
`define IRS_B_RUN  0
`define IRS_B_AUTO 1
`define IRS_B_FAST 2
`define IRS_B_REC  3
`define IRS_B_DIV  0
`define IRS_B_INV  2
`define IRS_B_SS   0
`define IRS_B_BIN  2
`define IRS_B_LFMT 3
`define IRS_B_FFMT 4
`define IRS_B_NFR  0
`define IRS_B_BF   8
`define IRS_B_BP   12

// ************************************************************
// Reset values and control write mask
// ************************************************************
`define IRS_R_CTRL 16'h0000
`define IRS_R_CFG  16'h0000
`define IRS_R_GLB  16'h0018
`define IRS_R_SEQ  16'h0000
`define IRS_R_ROWS 16'h0411
`define IRS_R_COLS 16'h0511
`define IRS_R_OVS  16'h0008
`define IRS_R_DLN  16'h0008
`define IRS_R_DPX  16'h0008
`define IRS_R_HBL  16'h0010
`define IRS_R_EXP  16'h0010
`define IRS_M_CTRL 16'h000F

// ************************************************************
// Modes and steps
// ************************************************************
`define IRS_SS_2X2  2'h1
`define IRS_SS_4X4  2'h2
`define IRS_DIV2    2'h1
`define IRS_DIV4    2'h2
`define IRS_STEP1   12'h001
`define IRS_STEP2X2 12'h003
`define IRS_STEP4X4 12'h007

`endif

// File: hw/irs_seq.v
// Purpose: readout sequencer and parallel pixel port of an image sensor
// Assumes: one clock CLK, synchronous active-high RST, ADC_DATA on CLK
// Notes  : registers reached over a plain address/strobe port
//
// Overview of operation
// - Rows scan in rising order; each pixel leaves as a 10-bit word.
// - Every line, dummy ones too, lasts one common line time.
// - Four-by-four subsampling reads two, skips six on rows and columns.
// - A two-by-two subsampling mode reads two, skips two.
// - Binning averages each pixel with its same-colour neighbour in a line.
// - Output is limited to a programmable region inside the overscan border.
// - With both formats set, frame-valid rises on the first physical line.
// - Blanked frames keep frame-valid low throughout.
// - Line-valid covers only region pixels on region lines.
// - Frame-valid falls after the last pixel of the last physical line.
// - Dummy lines and pixels are clocked; both lie outside line-valid, and dummy lines outside frame-valid too.
// - The overscan border width is programmable.
// - Data change on one clock edge, chosen by software; receiver uses other.
// - Pixel clock runs for every scanned pixel, stops in line blanking.
// - Pixel clock is a gated register toggled per internal clock tick, at CLK divided by 2, 4, 8.
// - A sequence first resets N lines before reading any line.
// - Afterwards each line reads one row while resetting another.
// - A rising run bit starts an acquisition.
// - Start or auto-start stops the current sequence and restarts in a record.
// - A sequence ends when the frame counter is zero at frame end.
// - Clearing run finishes the line, or stops at once under fast stop.
//
// Local design decisions: strobed register access and the register offsets.
`timescale 1ns/10ps
`include "irs_defines.vh"
`default_nettype none

module irs_seq (
  input  wire        CLK,
  input  wire        RST,
  input  wire [7:0]  ADDR,
  input  wire [15:0] WDATA,
  input  wire        WR,
  input  wire        RD,
  output wire [15:0] RDATA,
  input  wire [9:0]  ADC_DATA,
  output wire [9:0]  PIXEL_WORD_BUS,
  output wire        PIXEL_WORD_CLOCK,
  output wire        FRAME_VALID,
  output wire        LINE_VALID,
  output wire [11:0] ROW_ADDR,
  output wire [11:0] COL_ADDR,
  output wire [11:0] RST_ROW,
  output wire        RST_STB
);

  localparam [1:0] S_IDLE = 2'h0;
  localparam [1:0] S_PIX  = 2'h1;
  localparam [1:0] S_HBL  = 2'h2;

  // ************************************************************
  // Registers and state
  // ************************************************************
  reg [15:0] cam_ctrl_r;
  reg [15:0] cfg_r;
  reg [15:0] glb_r;
  reg [15:0] seqa_r;
  reg [15:0] seqb_r;
  reg [15:0] rows_r;
  reg [15:0] cols_r;
  reg [15:0] ovs_r;
  reg [15:0] dln_r;
  reg [15:0] dpx_r;
  reg [15:0] hbl_r;
  reg [15:0] exp_r;
  reg [15:0] rdata_r;
  reg [1:0]  dcnt_r;
  reg [1:0]  st_r;
  reg        ph_r;
  reg        rd_r;
  reg        go_r;
  reg        stop_r;
  reg        fend_r;
  reg        blank_r;
  reg        rec_r;
  reg        inph_r;
  reg [11:0] ic_r;
  reg [11:0] row_r;
  reg [11:0] dl_r;
  reg [11:0] rrow_r;
  reg [11:0] rdl_r;
  reg [11:0] col_r;
  reg [11:0] dp_r;
  reg [15:0] hb_r;
  reg [7:0]  frm_r;
  reg [3:0]  bf_r;
  reg [3:0]  bp_r;
  reg [3:0]  pc_r;
  reg [9:0]  b1_r;
  reg [9:0]  b2_r;
  reg [9:0]  pix_r;
  reg        pclk_r;
  reg        frame_r;
  reg        line_r;
  reg [11:0] rowo_r;
  reg [11:0] colo_r;
  reg [11:0] rrowo_r;
  reg        rstb_r;

  wire [11:0] nrow = rows_r[11:0];
  wire [11:0] ncol = cols_r[11:0];
  wire [11:0] ovs  = ovs_r[11:0];
  wire [11:0] ndl  = dln_r[11:0];
  wire [11:0] ndp  = dpx_r[11:0];
  wire [1:0]  ss   = glb_r[`IRS_B_SS+1:`IRS_B_SS];
  wire [1:0]  dsel = cfg_r[`IRS_B_DIV+1:`IRS_B_DIV];
  wire        inv  = cfg_r[`IRS_B_INV];
  wire        fast = cam_ctrl_r[`IRS_B_FAST];
  wire [15:0] seq_sel = cam_ctrl_r[`IRS_B_REC] ? seqb_r : seqa_r;

  // ************************************************************
  // Scan step helpers
  // ************************************************************
  // Next coordinate; skipped rows or columns are never scanned
  function [11:0] cstep;
    input [11:0] c;
    input [1:0]  m;
    begin
      if (m == `IRS_SS_4X4 && c[2:0] == 3'h1)
        cstep = c + `IRS_STEP4X4;
      else if (m == `IRS_SS_2X2 && c[1:0] == 2'h1)
        cstep = c + `IRS_STEP2X2;
      else
        cstep = c + `IRS_STEP1;
    end
  endfunction

  // Next line {wrap, row, dummy index}; rows from nrow on are dummy lines
  function [24:0] lstep;
    input [11:0] row;
    input [11:0] dl;
    input [11:0] nr;
    input [11:0] nd;
    input [1:0]  m;
    reg   [11:0] r;
    begin
      r = cstep(row, m);
      if (row < nr) begin
        if (r >= nr && nd == 12'h000)
          lstep = {1'b1, 24'h000000};
        else
          lstep = {1'b0, r, 12'h000};
      end else if (dl + 12'h001 >= nd) begin
        lstep = {1'b1, 24'h000000};
      end else begin
        lstep = {1'b0, row, dl + 12'h001};
      end
    end
  endfunction

  wire [24:0] dstep = lstep(row_r, dl_r, nrow, ndl, ss);
  wire [24:0] rstep = lstep(rrow_r, rdl_r, nrow, ndl, ss);

  // ************************************************************
  // Internal clock divider
  // ************************************************************
  // low-power division
  wire [1:0] dmax = (dsel == `IRS_DIV2) ? 2'h1 :
                    (dsel == `IRS_DIV4) ? 2'h3 : 2'h0;
  wire       ce   = (dcnt_r == dmax);

  always @(posedge CLK) begin
    if (RST) begin
      dcnt_r <= 2'h0;
    end else if (ce) begin
      dcnt_r <= 2'h0;
    end else begin
      dcnt_r <= dcnt_r + 2'h1;
    end
  end

  // ************************************************************
  // Next pixel slot
  // ************************************************************
  reg [11:0] p_col;
  reg [11:0] p_dp;
  reg        p_ph;
  reg        p_any;
  wire [11:0] cs     = cstep(col_r, ss);
  wire [10:0] bsum   = {1'b0, ADC_DATA} + {1'b0, b2_r};
  wire        rphys  = (row_r < nrow);
  wire        rroi   = rphys && row_r >= ovs && row_r < nrow - ovs;
  wire        croi   = p_col >= ovs && p_col < ncol - ovs;
  wire        win    = glb_r[`IRS_B_FFMT] ? rphys : rroi;
  wire [11:0] wend   = glb_r[`IRS_B_FFMT] ? nrow : nrow - ovs;
  wire        lastw  = win && (cstep(row_r, ss) >= wend);
  wire        shown  = rd_r && !blank_r;
  // average with the pixel two scanned columns back
  wire [9:0]  pval   = glb_r[`IRS_B_BIN] ? bsum[10:1] : ADC_DATA;

  // Slot after the current one, or the first slot of the line
  always @* begin
    p_col = col_r;
    p_dp  = 12'h000;
    p_ph  = 1'b0;
    p_any = 1'b0;
    if (st_r == S_HBL) begin
      p_col = 12'h000;
      p_ph  = (ncol != 12'h000);
      p_any = p_ph || (ndp != 12'h000);
    end else if (inph_r) begin
      p_col = cs;
      p_ph  = (cs < ncol);
      p_any = p_ph || (ndp != 12'h000);
    end else begin
      p_dp  = dp_r + 12'h001;
      p_any = (p_dp < ndp);
    end
  end

  wire lfull  = glb_r[`IRS_B_LFMT] ? (rroi && croi) : rphys;
  wire p_line = shown && p_ph && lfull;
  // dummy pixel slots stay inside frame-valid except after the last window line
  wire p_frame = shown && win && (p_ph || !lastw);

  // ************************************************************
  // Sequencer
  // ************************************************************
  // Events from a control write; run edge seen against the held bit
  wire wr_ctrl  = WR && (ADDR == `IRS_A_CTRL);
  wire run_old  = cam_ctrl_r[`IRS_B_RUN];
  wire run_new  = WDATA[`IRS_B_RUN];
  wire start_ev = wr_ctrl && run_new && (!run_old || WDATA[`IRS_B_AUTO]);
  wire stop_ev  = wr_ctrl && !run_new && run_old;

  always @(posedge CLK) begin
    if (RST) begin
      st_r    <= S_IDLE;
      ph_r    <= 1'b0;
      rd_r    <= 1'b0;
      go_r    <= 1'b0;
      stop_r  <= 1'b0;
      fend_r  <= 1'b0;
      blank_r <= 1'b0;
      rec_r   <= 1'b0;
      inph_r  <= 1'b0;
      ic_r    <= 12'h000;
      row_r   <= 12'h000;
      dl_r    <= 12'h000;
      rrow_r  <= 12'h000;
      rdl_r   <= 12'h000;
      col_r   <= 12'h000;
      dp_r    <= 12'h000;
      hb_r    <= 16'h0000;
      frm_r   <= 8'h00;
      bf_r    <= 4'h0;
      bp_r    <= 4'h0;
      pc_r    <= 4'h0;
      b1_r    <= 10'h000;
      b2_r    <= 10'h000;
      pix_r   <= 10'h000;
      pclk_r  <= 1'b0;
      frame_r <= 1'b0;
      line_r  <= 1'b0;
      rowo_r  <= 12'h000;
      colo_r  <= 12'h000;
      rrowo_r <= 12'h000;
      rstb_r  <= 1'b0;
    end else begin
      rstb_r <= 1'b0;
      if (st_r == S_IDLE) begin
        if (go_r) begin
          // Fresh sequence in the selected record
          go_r    <= 1'b0;
          rec_r   <= cam_ctrl_r[`IRS_B_REC];
          row_r   <= 12'h000;
          dl_r    <= 12'h000;
          rrow_r  <= 12'h000;
          rdl_r   <= 12'h000;
          ic_r    <= exp_r[11:0];
          rd_r    <= (exp_r[11:0] == 12'h000);
          frm_r   <= seq_sel[`IRS_B_NFR+7:`IRS_B_NFR];
          bp_r    <= seq_sel[`IRS_B_BP+3:`IRS_B_BP];
          pc_r    <= seq_sel[`IRS_B_BP+3:`IRS_B_BP];
          bf_r    <= seq_sel[`IRS_B_BF+3:`IRS_B_BF] -
                     {3'h0, seq_sel[`IRS_B_BF+3:`IRS_B_BF] != 4'h0};
          blank_r <= (seq_sel[`IRS_B_BF+3:`IRS_B_BF] != 4'h0);
          fend_r  <= 1'b0;
          hb_r    <= hbl_r;
          st_r    <= S_HBL;
        end
      end else if (stop_r && fast) begin
        st_r    <= S_IDLE;
        stop_r  <= 1'b0;
        rd_r    <= 1'b0;
        pclk_r  <= 1'b0;
        frame_r <= 1'b0;
        line_r  <= 1'b0;
        pix_r   <= 10'h000;
      end else if (ce) begin
        case (st_r)
          S_PIX: begin
            ph_r <= ~ph_r;
            if (!ph_r) begin
              // clock high half of the slot, low half when inverted
              pclk_r <= rd_r & ~inv;
            end else if (p_any) begin
              // data change on the chosen edge
              pclk_r  <= rd_r & inv;
              col_r   <= p_col;
              dp_r    <= p_dp;
              inph_r  <= p_ph;
              colo_r  <= p_col;
              pix_r   <= (rd_r && p_ph && rphys) ? pval : 10'h000;
              line_r  <= p_line;
              frame_r <= p_frame;
              if (p_ph) begin
                b1_r <= ADC_DATA;
                b2_r <= b1_r;
              end
            end else begin
              // Line end: clock stops for blanking
              st_r    <= S_HBL;
              hb_r    <= hbl_r;
              pclk_r  <= 1'b0;
              line_r  <= 1'b0;
              pix_r   <= 10'h000;
              frame_r <= frame_r & ~lastw;
              rrow_r  <= rstep[23:12];
              rdl_r   <= rstep[11:0];
              if (ic_r != 12'h000) begin
                ic_r <= ic_r - 12'h001;
                rd_r <= (ic_r == 12'h001);
              end
              if (rd_r) begin
                row_r <= dstep[23:12];
                dl_r  <= dstep[11:0];
              end
              if (rd_r && dstep[24]) begin
                // frame counter checked at frame end
                fend_r <= (frm_r == 8'h00);
                frm_r  <= frm_r - {7'h00, frm_r != 8'h00};
                if (bf_r != 4'h0) begin
                  blank_r <= 1'b1;
                  bf_r    <= bf_r - 4'h1;
                end else if (bp_r != 4'h0 && pc_r <= 4'h1) begin
                  blank_r <= 1'b1;
                  pc_r    <= bp_r;
                end else begin
                  blank_r <= 1'b0;
                  pc_r    <= pc_r - {3'h0, pc_r != 4'h0};
                end
              end
            end
          end
          S_HBL: begin
            // blanking is the same for every line
            if (hb_r != 16'h0000) begin
              hb_r <= hb_r - 16'h0001;
            end else if (stop_r || fend_r) begin
              st_r    <= S_IDLE;
              stop_r  <= 1'b0;
              rd_r    <= 1'b0;
              frame_r <= 1'b0;
            end else begin
              // First slot of the next line
              st_r    <= S_PIX;
              ph_r    <= 1'b0;
              pclk_r  <= rd_r & inv;
              rstb_r  <= (rrow_r < nrow);
              rrowo_r <= rrow_r;
              rowo_r  <= row_r;
              col_r   <= p_col;
              dp_r    <= p_dp;
              inph_r  <= p_ph;
              colo_r  <= p_col;
              pix_r   <= (rd_r && p_ph && rphys) ? pval : 10'h000;
              line_r  <= p_line;
              frame_r <= p_frame;
              if (p_ph) begin
                b1_r <= ADC_DATA;
                b2_r <= b1_r;
              end
            end
          end
          default: begin
            st_r <= S_IDLE;
          end
        endcase
      end
      // Control writes last so a request is never lost
      // stop current then restart
      if (start_ev) begin
        go_r <= 1'b1;
        if (st_r != S_IDLE)
          stop_r <= 1'b1;
      end
      if (stop_ev) begin
        go_r   <= 1'b0;
        stop_r <= (st_r != S_IDLE);
      end
    end
  end

  // ************************************************************
  // Register port
  // ************************************************************
  // Writes; status is read only
  always @(posedge CLK) begin
    if (RST) begin
      cam_ctrl_r <= `IRS_R_CTRL;
      cfg_r      <= `IRS_R_CFG;
      glb_r      <= `IRS_R_GLB;
      seqa_r     <= `IRS_R_SEQ;
      seqb_r     <= `IRS_R_SEQ;
      rows_r     <= `IRS_R_ROWS;
      cols_r     <= `IRS_R_COLS;
      ovs_r      <= `IRS_R_OVS;
      dln_r      <= `IRS_R_DLN;
      dpx_r      <= `IRS_R_DPX;
      hbl_r      <= `IRS_R_HBL;
      exp_r      <= `IRS_R_EXP;
    end else if (WR) begin
      case (ADDR)
        `IRS_A_CTRL: cam_ctrl_r <= WDATA & `IRS_M_CTRL;
        `IRS_A_CFG:  cfg_r      <= WDATA;
        `IRS_A_GLB:  glb_r      <= WDATA;
        `IRS_A_SEQA: seqa_r     <= WDATA;
        `IRS_A_SEQB: seqb_r     <= WDATA;
        `IRS_A_ROWS: rows_r     <= WDATA;
        `IRS_A_COLS: cols_r     <= WDATA;
        `IRS_A_OVS:  ovs_r      <= WDATA;
        `IRS_A_DLN:  dln_r      <= WDATA;
        `IRS_A_DPX:  dpx_r      <= WDATA;
        `IRS_A_HBL:  hbl_r      <= WDATA;
        `IRS_A_EXP:  exp_r      <= WDATA;
        default:     cam_ctrl_r <= cam_ctrl_r;
      endcase
    end
  end

  // Read data valid one cycle after the strobe, zero otherwise
  always @(posedge CLK) begin
    if (RST) begin
      rdata_r <= 16'h0000;
    end else if (!RD) begin
      rdata_r <= 16'h0000;
    end else begin
      case (ADDR)
        `IRS_A_CTRL: rdata_r <= cam_ctrl_r;
        `IRS_A_CFG:  rdata_r <= cfg_r;
        `IRS_A_GLB:  rdata_r <= glb_r;
        `IRS_A_STAT: rdata_r <= {10'h000, dsel, blank_r, rec_r,
                                 rd_r, st_r != S_IDLE};
        `IRS_A_SEQA: rdata_r <= seqa_r;
        `IRS_A_SEQB: rdata_r <= seqb_r;
        `IRS_A_ROWS: rdata_r <= rows_r;
        `IRS_A_COLS: rdata_r <= cols_r;
        `IRS_A_OVS:  rdata_r <= ovs_r;
        `IRS_A_DLN:  rdata_r <= dln_r;
        `IRS_A_DPX:  rdata_r <= dpx_r;
        `IRS_A_HBL:  rdata_r <= hbl_r;
        `IRS_A_EXP:  rdata_r <= exp_r;
        default:     rdata_r <= 16'h0000;
      endcase
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  // receiver ignores data while strobes are low
  assign RDATA            = rdata_r;
  assign PIXEL_WORD_BUS   = pix_r;
  assign PIXEL_WORD_CLOCK = pclk_r;
  assign FRAME_VALID      = frame_r;
  assign LINE_VALID       = line_r;
  assign ROW_ADDR         = rowo_r;
  assign COL_ADDR         = colo_r;
  assign RST_ROW          = rrowo_r;
  assign RST_STB          = rstb_r;

endmodule

`default_nettype wire

// File: tb/irs_seq_properties.sv
// Purpose: port assertions for the readout sequencer
// Assumes: one clock CLK, RST synchronous active high
// Notes  : bound to every irs_seq instance at the foot
`timescale 1ns/10ps
`default_nettype none
module irs_seq_props (
  input wire logic        CLK,
  input wire logic        RST,
  input wire logic [7:0]  ADDR,
  input wire logic [15:0] WDATA,
  input wire logic        WR,
  input wire logic        RD,
  input wire logic [15:0] RDATA,
  input wire logic        PIXEL_WORD_CLOCK,
  input wire logic        FRAME_VALID,
  input wire logic        LINE_VALID,
  input wire logic [11:0] ROW_ADDR,
  input wire logic [11:0] COL_ADDR,
  input wire logic        RST_STB
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking dc @(posedge CLK);
  endclocking
  default disable iff (RST);
  AST_IDLE_AFTER_RST: assert property (
    $fell(RST) |-> !FRAME_VALID && !LINE_VALID && !PIXEL_WORD_CLOCK)
    else $error("outputs active after reset");
  AST_LINE_IN_FRAME: assert property (LINE_VALID |-> FRAME_VALID)
    else $error("line strobe outside frame strobe");
  AST_ROW_RISES: assert property (
    FRAME_VALID && $past(FRAME_VALID) && $changed(ROW_ADDR) |-> ROW_ADDR > $past(ROW_ADDR))
    else $error("row order not rising");
  AST_RST_STB_PULSE: assert property (RST_STB |=> !RST_STB)
    else $error("reset strobe longer than a cycle");
  AST_LINE_AT_SLOT: assert property ($changed(LINE_VALID) |-> $changed(COL_ADDR))
    else $error("line strobe moved inside a pixel slot");
  AST_FRAME_AT_COL0: assert property ($rose(FRAME_VALID) |-> COL_ADDR == 12'h000)
    else $error("frame strobe rose off line start");
  AST_FRAME_FALL: assert property ($fell(FRAME_VALID) |-> !LINE_VALID)
    else $error("frame fell with line still high");
  AST_CLK_IN_LINE: assert property (
    $rose(LINE_VALID) |-> ##[1:6] $changed(PIXEL_WORD_CLOCK))
    else $error("pixel clock idle inside line");
  AST_FAST_STOP: assert property (
    WR && ADDR == 8'h03 && !WDATA[0] && WDATA[2]
    |-> ##[1:3] (!FRAME_VALID && !LINE_VALID && !PIXEL_WORD_CLOCK))
    else $error("fast stop left port active");
  // Read data only in the answer cycle
  AST_RDATA_QUIET: assert property (!$past(RD) |-> RDATA == 16'h0000)
    else $error("read data outside answer cycle");
  // Main scenarios seen
  COV_FRAME: cover property ($rose(FRAME_VALID));
  COV_LINE_END: cover property ($fell(LINE_VALID));
  COV_RESET_ROW: cover property (RST_STB);
endmodule
bind irs_seq irs_seq_props irs_seq_props_i (
  .CLK(CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
  .PIXEL_WORD_CLOCK(PIXEL_WORD_CLOCK), .FRAME_VALID(FRAME_VALID),
  .LINE_VALID(LINE_VALID), .ROW_ADDR(ROW_ADDR), .COL_ADDR(COL_ADDR), .RST_STB(RST_STB));
`default_nettype wire

// File: tb/irs_isp_model.sv
// Purpose: receiving image processor on the pixel port
// Assumes: strobes and words settle at slot start
// Notes  : cnt holds frames, lines, pixels, clock rises, bad words
`timescale 1ns/10ps
`default_nettype none
module irs_isp_model (
  input  wire logic        pclk,
  input  wire logic        inv,
  input  wire logic        fv,
  input  wire logic        lv,
  input  wire logic [9:0]  data,
  input  wire logic [9:0]  exp_data,
  input  wire logic [31:0] exp_per,
  output var  logic [31:0] cnt [5]
);
  realtime t_last;
  logic    seen;
  // ****************************************
  // Receiver
  // ****************************************
  // drop unqualified words
  task automatic take;
    if (fv && lv) begin
      cnt[2] <= cnt[2] + 1;
      if (data !== exp_data || (seen && $realtime - t_last != exp_per))
        cnt[4] <= cnt[4] + 1;
      seen = 1'b1;
      t_last = $realtime;
    end else
      seen = 1'b0;
  endtask
  // Counters start clean
  initial begin
    seen = 1'b0;
    for (int k = 0; k < 5; k++)
      cnt[k] = 32'h0;
  end
  // Frame and line openings
  always @(posedge fv) cnt[0] <= cnt[0] + 1;
  always @(posedge lv) cnt[1] <= cnt[1] + 1;
  always @(posedge pclk) begin
    cnt[3] <= cnt[3] + 1;
    if (!inv)
      take();
  end
  // Inverted clock moves the sampling edge
  always @(negedge pclk) begin
    if (inv)
      take();
  end
endmodule
`default_nettype wire

// File: tb/tb.sv
// Purpose: self-checking bench for the readout sequencer
// Assumes: 32x32 array, border 8, 8 dummy lines and pixels
// Notes  : pixel value held fixed per run so binning keeps it
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic        CLK = 1'b0;
  logic        RST = 1'b1;
  logic        WR = 1'b0;
  logic        RD = 1'b0;
  logic [7:0]  ADDR = 8'h00;
  logic [15:0] WDATA = 16'h0000;
  logic [9:0]  ADC_DATA = 10'h000;
  logic [15:0] RDATA;
  logic [9:0]  PIXEL_WORD_BUS;
  logic        PIXEL_WORD_CLOCK;
  logic        FRAME_VALID;
  logic        LINE_VALID;
  logic [11:0] ROW_ADDR;
  logic [11:0] COL_ADDR;
  logic [11:0] RST_ROW;
  logic        RST_STB;
  logic        inv_r = 1'b0;
  logic [31:0] per_r = 32'h8;
  logic [31:0] cnt [5];
  logic [31:0] s [5];
  logic [15:0] d;
  integer      seed = 93339;
  integer      failures = 0;
  integer      total_checks = 0;
  integer      ex [5];
  integer      ss, dv, fr, rs, rl;
  integer      er = 0;
  integer      nrs = 0;
  string       nm [5] = '{"frames", "lines", "pixels", "clocks", "bad words"};
  logic [7:0]  ra [7] = '{8'h03, 8'h04, 8'h05, 8'h06, 8'h20, 8'h21, 8'h22};
  logic [15:0] rv [7] = '{16'h0000, 16'h0000, 16'h0018, 16'h0000, 16'h0411, 16'h0511, 16'h0008};
  logic [7:0]  ga [7] = '{8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h26};
  logic [15:0] gv [7] = '{16'h0020, 16'h0020, 16'h0008, 16'h0008, 16'h0008, 16'h0010, 16'h0004};
  // 250 MHz clock
  always #2 CLK = ~CLK;
  irs_seq irs_seq_i (.CLK(CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .ADC_DATA(ADC_DATA), .PIXEL_WORD_BUS(PIXEL_WORD_BUS),
    .PIXEL_WORD_CLOCK(PIXEL_WORD_CLOCK), .FRAME_VALID(FRAME_VALID), .LINE_VALID(LINE_VALID),
    .ROW_ADDR(ROW_ADDR), .COL_ADDR(COL_ADDR), .RST_ROW(RST_ROW), .RST_STB(RST_STB));
  irs_isp_model irs_isp_model_i (.pclk(PIXEL_WORD_CLOCK), .inv(inv_r), .fv(FRAME_VALID),
    .lv(LINE_VALID), .data(PIXEL_WORD_BUS), .exp_data(ADC_DATA), .exp_per(per_r), .cnt(cnt));
  // ****************************************
  // Bus and compare tasks
  // ****************************************
  task wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= v;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask
  // Answer is taken at the edge closing the answer cycle
  task rd(input logic [7:0] a, output logic [15:0] v);
    @(posedge CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    @(posedge CLK);
    v = RDATA;
  endtask
  task chk_reg(input string n, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  task chk_cnt(input string n, input integer e, input logic [31:0] g);
    total_checks++;
    if (g !== e[31:0]) begin
      failures++;
      $display("[ERR] %s exp %0d got %0d", n, e, g);
    end
  endtask
  task give_verdict;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Bounded poll of the busy flag
  task wait_idle;
    integer n;
    n = 0;
    d = 16'h0001;
    while (d[0] !== 1'b0 && n < 8000) begin
      rd(8'h06, d);
      n++;
    end
    if (n >= 8000) begin
      failures++;
      $display("[ERR] idle wait exp 0 got 1");
      give_verdict();
    end
  endtask
  // Reference count of kept rows or columns in a span
  function automatic integer nsub(integer m, integer lo, integer hi);
    integer c;
    c = 0;
    for (integer i = lo; i < hi; i++)
      if (m == 0 || (m == 1 && i % 4 < 2) || (m == 2 && i % 8 < 2))
        c++;
    return c;
  endfunction
  // Next kept row after r, wrapping to row zero past the array
  function automatic integer nkeep(integer m, integer r);
    integer c;
    c = r + 1;
    while (c < 32 && nsub(m, c, c + 1) == 0)
      c++;
    return (c < 32) ? c : 0;
  endfunction
  // Reset strobes walk the kept rows; any control write restarts the walk
  always @(posedge CLK) begin
    if (WR && ADDR == 8'h03) begin
      er <= 0;
      nrs <= 0;
    end else if (RST_STB) begin
      chk_cnt("reset row", er, {20'h0, RST_ROW});
      er <= nkeep(ss, er);
      nrs <= nrs + 1;
    end
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (3) @(posedge CLK);
    RST <= 1'b0;
    for (int k = 0; k < 7; k++) begin
      rd(ra[k], d);
      chk_reg("reset value", rv[k], d);
    end
    wr(8'h03, 16'hFFF0);
    rd(8'h03, d);
    chk_reg("control mask", 16'h0000, d);
    wr(8'h06, 16'hFFFF);
    rd(8'h06, d);
    chk_reg("status write", 16'h0000, d);
    rd(8'h7F, d);
    chk_reg("unmapped", 16'h0000, d);
    for (int k = 0; k < 7; k++) begin
      wr(ga[k], gv[k]);
      rd(ga[k], d);
      chk_reg("geometry", gv[k], d);
    end
    // Every subsample, divider, invert and binning setting; one run with a blanked first frame
    for (int m = 0; m < 6; m++) begin
      ss = m % 3;
      dv = (m + 1) % 3;
      inv_r <= m[0];
      per_r <= 32'h8 << dv;
      ADC_DATA <= 10'($random(seed));
      wr(8'h04, {13'h0, m[0], dv[1:0]});
      wr(8'h05, {11'h0, 2'b11, (m > 2), ss[1:0]});
      wr(8'h17, (m == 5) ? 16'h0101 : 16'h0001);
      s = cnt;
      rs = nsub(ss, 0, 32);
      wr(8'h03, 16'h0001);
      wait_idle();
      chk_cnt("reset lines", 4 + 2 * rs, nrs);
      wr(8'h03, 16'h0000);
      fr = (m == 5) ? 1 : 2;
      rl = nsub(ss, 8, 24);
      ex = '{fr, fr * rl, fr * rl * rl, 2 * (rs + 8) * (rs + 8), 0};
      for (int k = 0; k < 5; k++)
        chk_cnt(nm[k], ex[k], cnt[k] - s[k]);
    end
    // Normal stop mid-frame finishes the line
    inv_r <= 1'b0;
    per_r <= 32'h8;
    ss = 0;
    wr(8'h04, 16'h0000);
    wr(8'h05, 16'h0018);
    wr(8'h17, 16'h00FF);
    s = cnt;
    wr(8'h03, 16'h0001);
    // Stop lands mid-way through a region line, so a cut line would show
    repeat (1990) @(posedge CLK);
    wr(8'h03, 16'h0000);
    wait_idle();
    chk_cnt("line tail", 0, (cnt[2] - s[2]) % 16);
    // Record select, auto restart, fast stop
    wr(8'h03, 16'h0009);
    rd(8'h06, d);
    chk_reg("record b", 16'h0005, d & 16'h0005);
    wr(8'h03, 16'h0003);
    // Record is taken only once the old sequence has wound down
    repeat (120) @(posedge CLK);
    rd(8'h06, d);
    chk_reg("restart a", 16'h0001, d & 16'h0005);
    wr(8'h03, 16'h000C);
    rd(8'h06, d);
    chk_reg("fast stop", 16'h0000, d & 16'h0001);
    give_verdict();
  end
endmodule
`default_nettype wire
